// >>> src/cpcb_cfg.svh
`ifndef CPCB_CFG_SVH
`define CPCB_CFG_SVH

// Timing
`define CPCB_CLK_MHZ          50
`define CPCB_FP_PERIOD_MS     36
`define CPCB_LP_STEP_MS       200
`define CPCB_FP_PERIOD_CYC    (`CPCB_FP_PERIOD_MS * 1000 * `CPCB_CLK_MHZ)
`define CPCB_LP_STEP_CYC      (`CPCB_LP_STEP_MS * 1000 * `CPCB_CLK_MHZ)

// Address map
`define CPCB_PWR_ADDR         10'h000
`define CPCB_BANK1_LAST       10'h007
`define CPCB_STAT_FIRST       10'h008
`define CPCB_STAT_LAST        10'h00A
`define CPCB_BANK2_BASE       10'h080
`define CPCB_BANK2_LAST       10'h0DF
`define CPCB_BANK3_BASE       10'h0E0
`define CPCB_BANK3_LAST       10'h28F
`define CPCB_ADDR_MAX         10'h28F
`define CPCB_ADDR_STEP        10'h001
`define CPCB_STAGE_RES_WORDS  10'h024
`define CPCB_BANK2_WORDS      96
`define CPCB_NUM_STAGES       12
`define CPCB_MAX_STAGE        4'hB

// Power control fields
`define CPCB_F_MODE           1:0
`define CPCB_F_LPDLY          3:2
`define CPCB_F_SEQN           7:4
`define CPCB_F_DEC            9:8
`define CPCB_B_SRST           10
`define CPCB_B_INTPOL         11
`define CPCB_B_EXCG           12
`define CPCB_F_BIAS           15:14
`define CPCB_PWR_STORE_MASK   16'hDBFF
`define CPCB_REG_RESET        16'h0000

// Decimation ratios
`define CPCB_DEC_CODE_256     2'h0
`define CPCB_DEC_CODE_128     2'h1
`define CPCB_DEC_256          9'h100
`define CPCB_DEC_128          9'h080
`define CPCB_DEC_64           9'h040

`endif

// >>> src/cpcb_pkg.sv
package cpcb_pkg;

   typedef enum logic [1:0] {
      cpcb_mode_full   = 2'h0,
      cpcb_mode_shut_a = 2'h1,
      cpcb_mode_low    = 2'h2,
      cpcb_mode_shut_b = 2'h3
   } cpcb_mode_t;

   typedef enum logic [2:0] {
      cpcb_st_idle    = 3'h1,
      cpcb_st_convert = 3'h2,
      cpcb_st_commit  = 3'h4
   } cpcb_seq_state_t;

endpackage

// >>> src/cpcb_seq_timer.sv
`timescale 1ns/10ps
`include "cpcb_cfg.svh"

module cpcb_seq_timer #(
   parameter int unsigned FP_PERIOD_CYC = `CPCB_FP_PERIOD_CYC,
   parameter int unsigned LP_STEP_CYC   = `CPCB_LP_STEP_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       restart,
   input  wire logic [1:0] mode,
   input  wire logic [1:0] lp_delay,
   output logic            seq_tick
);

   logic [31:0] count;
   logic [31:0] limit;
   logic        halted;

   assign halted = (mode == cpcb_pkg::cpcb_mode_shut_a) || (mode == cpcb_pkg::cpcb_mode_shut_b);

   always_comb begin
      if (mode == cpcb_pkg::cpcb_mode_full) begin
         limit = 32'(FP_PERIOD_CYC);
      end else begin
         limit = 32'(LP_STEP_CYC * (32'(lp_delay) + 32'h1));
      end
   end

   // Shutdown holds the count at zero so a wake-up waits one full interval
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count    <= 32'h0;
         seq_tick <= 1'b0;
      end else if (restart || halted) begin
         count    <= 32'h0;
         seq_tick <= 1'b0;
      end else if (count >= limit - 32'h1) begin
         count    <= 32'h0;
         seq_tick <= 1'b1;
      end else begin
         count    <= count + 32'h1;
         seq_tick <= 1'b0;
      end
   end

endmodule // cpcb_seq_timer

// >>> src/cpcb_top.sv
// How it works
// - Result words of stages 0 to N refresh automatically when every conversion sequence completes.
// - Stage configuration and result words have no reset value.
// - Twelve stage groups of eight words each, from 0x080 upward.
// - Mode 00 full power, 10 low power wake-up, 01/11 shutdown.
// - Full power repeats a sequence about every 36 ms.
// - Low power wakes every 200, 400, 600 or 800 ms.
// - Stage count field N runs N+1 stages, at most twelve.
// - Decimation code 00 gives 256, 01 gives 128, else 64.
// - Writing the soft restart bit restores defaults; it reads back zero.
// - Excitation gate zero drives sense inputs; one blocks them.
// - Bias trim code is passed to the analog bias control.
// - Registers are 16 bits, sent high byte first in pairs.
`timescale 1ns/10ps
`include "cpcb_cfg.svh"

module cpcb_top #(
   parameter int unsigned FP_PERIOD_CYC = `CPCB_FP_PERIOD_CYC,
   parameter int unsigned LP_STEP_CYC   = `CPCB_LP_STEP_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        link_clk,
   input  wire logic        link_addr_load,
   input  wire logic [9:0]  link_addr,
   input  wire logic        link_byte_valid,
   input  wire logic [7:0]  link_byte,
   input  wire logic        link_rd_req,
   output logic             link_busy,
   output logic             link_rd_valid,
   output logic [15:0]      link_rd_data,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_data,
   output logic             conv_start,
   output logic [3:0]       conv_stage,
   output logic [8:0]       decim_ratio,
   output logic             excitation_enable,
   output logic [1:0]       bias_trim,
   output logic             int_active_high
);

   function automatic logic cpcb_in_range(input logic [9:0] a, input logic [9:0] lo,
                                          input logic [9:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [9:0] cpcb_next_ptr(input logic [9:0] p);
      return (p == `CPCB_ADDR_MAX) ? p : p + `CPCB_ADDR_STEP;
   endfunction

   // ---------------- Link domain ----------------
   logic [9:0]  ptr;
   logic [7:0]  hi_byte;
   logic        have_hi;
   logic        req_tgl;
   logic        req_pend;
   logic        req_wr;
   logic [9:0]  req_addr;
   logic [15:0] req_data;
   logic        ack_s1;
   logic        ack_s2;
   logic        issue_wr;
   logic        issue_rd;
   logic        req_done;

   // Core-domain signals seen here
   logic        ack_tgl;
   logic [15:0] core_rd_data;

   assign issue_wr = link_byte_valid && have_hi && !req_pend && !link_addr_load;
   assign issue_rd = link_rd_req && !req_pend && !link_addr_load && !issue_wr;
   assign req_done = req_pend && (req_tgl == ack_s2);

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   // Address pointer stops at the top of the map instead of wrapping
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr     <= `CPCB_PWR_ADDR;
         have_hi <= 1'b0;
         hi_byte <= 8'h00;
      end else if (link_addr_load) begin
         ptr     <= link_addr;
         have_hi <= 1'b0;
      end else begin
         if (issue_wr || issue_rd) begin
            ptr <= cpcb_next_ptr(ptr);
         end
         if (link_byte_valid && !req_pend) begin
            if (!have_hi) begin
               hi_byte <= link_byte;
               have_hi <= 1'b1;
            end else begin
               have_hi <= 1'b0;
            end
         end
      end
   end

   // Payload holds still while pending, so the core can sample it whole
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_tgl  <= 1'b0;
         req_pend <= 1'b0;
         req_wr   <= 1'b0;
         req_addr <= `CPCB_PWR_ADDR;
         req_data <= `CPCB_REG_RESET;
      end else if (issue_wr || issue_rd) begin
         req_tgl  <= ~req_tgl;
         req_pend <= 1'b1;
         req_wr   <= issue_wr;
         req_addr <= ptr;
         req_data <= {hi_byte, link_byte};
      end else if (req_done) begin
         req_pend <= 1'b0;
      end
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         link_rd_valid <= 1'b0;
         link_rd_data  <= `CPCB_REG_RESET;
      end else begin
         link_rd_valid <= req_done && !req_wr;
         if (req_done && !req_wr) begin
            link_rd_data <= core_rd_data;
         end
      end
   end

   assign link_busy = req_pend;

   // ---------------- Core domain ----------------
   logic        req_s1;
   logic        req_s2;
   logic        req_s3;
   logic        req_evt;
   logic        wr_evt;
   logic        rd_evt;
   logic        soft_rst;
   logic [15:0] pwr;
   logic [15:0] bank1 [1:7];
   logic [15:0] stage_cfg [0:`CPCB_BANK2_WORDS-1];
   logic [15:0] shadow [0:`CPCB_NUM_STAGES-1];
   logic [15:0] result [0:`CPCB_NUM_STAGES-1];
   logic [15:0] rd_mux;
   logic [9:0]  b3_off;
   logic [9:0]  b2_off;
   logic [3:0]  last_stage;
   logic        seq_tick;
   logic        shutdown;
   cpcb_pkg::cpcb_seq_state_t state;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   assign req_evt  = req_s2 ^ req_s3;
   assign wr_evt   = req_evt && req_wr;
   assign rd_evt   = req_evt && !req_wr;
   assign soft_rst = wr_evt && (req_addr == `CPCB_PWR_ADDR) && req_data[`CPCB_B_SRST];
   assign b2_off   = req_addr - `CPCB_BANK2_BASE;
   assign b3_off   = req_addr - `CPCB_BANK3_BASE;

   // Soft restart discards the written word; the bit itself is never stored
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr <= `CPCB_REG_RESET;
         for (int i = 1; i <= 7; i++) begin
            bank1[i] <= `CPCB_REG_RESET;
         end
      end else if (soft_rst) begin
         pwr <= `CPCB_REG_RESET;
         for (int i = 1; i <= 7; i++) begin
            bank1[i] <= `CPCB_REG_RESET;
         end
      end else if (wr_evt) begin
         if (req_addr == `CPCB_PWR_ADDR) begin
            pwr <= req_data & `CPCB_PWR_STORE_MASK;
         end else if (cpcb_in_range(req_addr, `CPCB_PWR_ADDR + `CPCB_ADDR_STEP,
                                    `CPCB_BANK1_LAST)) begin
            bank1[3'(req_addr)] <= req_data;
         end
      end
   end

   // No reset: contents are undefined until the host loads them
   always_ff @(posedge core_clk) begin
      if (wr_evt && cpcb_in_range(req_addr, `CPCB_BANK2_BASE, `CPCB_BANK2_LAST)) begin
         stage_cfg[7'(b2_off)] <= req_data;
      end
   end

   always_comb begin
      rd_mux = `CPCB_REG_RESET;
      if (req_addr == `CPCB_PWR_ADDR) begin
         rd_mux = pwr;
      end else if (cpcb_in_range(req_addr, `CPCB_PWR_ADDR + `CPCB_ADDR_STEP,
                                 `CPCB_BANK1_LAST)) begin
         rd_mux = bank1[3'(req_addr)];
      end else if (cpcb_in_range(req_addr, `CPCB_BANK2_BASE, `CPCB_BANK2_LAST)) begin
         rd_mux = stage_cfg[7'(b2_off)];
      end else if (cpcb_in_range(req_addr, `CPCB_BANK3_BASE, `CPCB_BANK3_LAST) &&
                   ((b3_off % `CPCB_STAGE_RES_WORDS) == 10'h000)) begin
         rd_mux = result[4'(b3_off / `CPCB_STAGE_RES_WORDS)];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_tgl      <= 1'b0;
         core_rd_data <= `CPCB_REG_RESET;
      end else begin
         ack_tgl <= ack_tgl ^ req_evt;
         if (rd_evt) begin
            core_rd_data <= rd_mux;
         end
      end
   end

   // ---------------- Conversion sequencer ----------------
   assign shutdown = (pwr[`CPCB_F_MODE] == cpcb_pkg::cpcb_mode_shut_a) ||
                     (pwr[`CPCB_F_MODE] == cpcb_pkg::cpcb_mode_shut_b);
   assign last_stage = (pwr[`CPCB_F_SEQN] > `CPCB_MAX_STAGE) ? `CPCB_MAX_STAGE
                                                             : pwr[`CPCB_F_SEQN];

   cpcb_seq_timer #(
      .FP_PERIOD_CYC (FP_PERIOD_CYC),
      .LP_STEP_CYC   (LP_STEP_CYC)
   ) u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .restart  (soft_rst),
      .mode     (pwr[`CPCB_F_MODE]),
      .lp_delay (pwr[`CPCB_F_LPDLY]),
      .seq_tick (seq_tick)
   );

   // A sequence cut short by shutdown never reaches commit, so results stay whole
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= cpcb_pkg::cpcb_st_idle;
         conv_stage <= 4'h0;
         conv_start <= 1'b0;
      end else if (soft_rst || shutdown) begin
         state      <= cpcb_pkg::cpcb_st_idle;
         conv_stage <= 4'h0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         unique case (state)
            cpcb_pkg::cpcb_st_idle: begin
               if (seq_tick) begin
                  conv_stage <= 4'h0;
                  conv_start <= 1'b1;
                  state      <= cpcb_pkg::cpcb_st_convert;
               end
            end
            cpcb_pkg::cpcb_st_convert: begin
               if (conv_done) begin
                  if (conv_stage >= last_stage) begin
                     state <= cpcb_pkg::cpcb_st_commit;
                  end else begin
                     conv_stage <= conv_stage + 4'h1;
                     conv_start <= 1'b1;
                  end
               end
            end
            cpcb_pkg::cpcb_st_commit: begin
               state <= cpcb_pkg::cpcb_st_idle;
            end
            default: begin
               state <= cpcb_pkg::cpcb_st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if ((state == cpcb_pkg::cpcb_st_convert) && conv_done) begin
         shadow[conv_stage] <= conv_data;
      end
   end

   // Host never sees a half-updated sequence
   always_ff @(posedge core_clk) begin
      if (state == cpcb_pkg::cpcb_st_commit) begin
         for (int i = 0; i < `CPCB_NUM_STAGES; i++) begin
            if (4'(i) <= last_stage) begin
               result[i] <= shadow[i];
            end
         end
      end
   end

   // ---------------- Analog controls ----------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         decim_ratio       <= `CPCB_DEC_256;
         excitation_enable <= 1'b1;
         bias_trim         <= 2'h0;
         int_active_high   <= 1'b0;
      end else begin
         unique case (pwr[`CPCB_F_DEC])
            `CPCB_DEC_CODE_256: decim_ratio <= `CPCB_DEC_256;
            `CPCB_DEC_CODE_128: decim_ratio <= `CPCB_DEC_128;
            default:            decim_ratio <= `CPCB_DEC_64;
         endcase
         excitation_enable <= !pwr[`CPCB_B_EXCG];
         bias_trim         <= pwr[`CPCB_F_BIAS];
         int_active_high   <= pwr[`CPCB_B_INTPOL];
      end
   end

endmodule // cpcb_top

// >>> sim/cpcb_top_monitor.sv
`timescale 1ns/10ps

module cpcb_top_monitor (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        link_clk,
   input wire logic        link_addr_load,
   input wire logic        link_byte_valid,
   input wire logic        link_rd_req,
   input wire logic        link_busy,
   input wire logic        link_rd_valid,
   input wire logic [15:0] link_rd_data,
   input wire logic        conv_done,
   input wire logic        conv_start,
   input wire logic [3:0]  conv_stage,
   input wire logic [8:0]  decim_ratio,
   input wire logic        excitation_enable,
   input wire logic [1:0]  bias_trim
);
   sequence s_read_taken;
      link_rd_req && !link_busy && !link_addr_load && !link_byte_valid;
   endsequence
   sequence s_read_answer;
      link_busy ##[1:20] (!link_busy && link_rd_valid);
   endsequence

   a_read_answer: assert property (@(posedge link_clk) disable iff (!reset_n)
      s_read_taken |=> s_read_answer) else $error("read not answered in time");
   a_rdv_pulse: assert property (@(posedge link_clk) disable iff (!reset_n)
      link_rd_valid |=> !link_rd_valid) else $error("read valid longer than one cycle");
   a_busy_bound: assert property (@(posedge link_clk) disable iff (!reset_n)
      $rose(link_busy) |-> ##[1:20] !link_busy) else $error("busy stuck high");
   a_rd_hold: assert property (@(posedge link_clk) disable iff (!reset_n)
      $changed(link_rd_data) |-> link_rd_valid) else $error("read data moved without valid");
   a_reset_defaults: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(reset_n) |-> decim_ratio == 9'h100 && excitation_enable && bias_trim == 2'h0)
      else $error("outputs not at defaults after reset");
   a_decim_legal: assert property (@(posedge core_clk) disable iff (!reset_n)
      decim_ratio inside {9'h100, 9'h080, 9'h040}) else $error("illegal decimation ratio");
   a_start_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_start |=> !conv_start) else $error("start held over two cycles");
   a_stage_max: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_start |-> conv_stage <= 4'hB) else $error("stage index above eleven");
   a_stage_next: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_start && conv_stage != 4'h0 |-> $past(conv_done) && conv_stage == $past(conv_stage) + 4'h1)
      else $error("stage started out of order");
endmodule // cpcb_top_monitor

bind cpcb_top cpcb_top_monitor i_mon (.core_clk, .reset_n, .link_clk, .link_addr_load,
   .link_byte_valid, .link_rd_req, .link_busy, .link_rd_valid, .link_rd_data, .conv_done,
   .conv_start, .conv_stage, .decim_ratio, .excitation_enable, .bias_trim);

// >>> sim/cpcb_conv_model.sv
`timescale 1ns/10ps

module cpcb_conv_model #(
   parameter int DLY = 4
) (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        conv_start,
   input  wire logic [3:0]  conv_stage,
   output logic             conv_done,
   output logic [15:0]      conv_data
);
   int         cnt;
   logic [3:0] stg;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         stg <= 4'h0;
         conv_done <= 1'b0;
         conv_data <= 16'h0000;
      end else begin
         conv_done <= 1'b0;
         // Toggles outside the done cycle so a late sample is caught
         conv_data <= ~conv_data;
         if (conv_start) begin
            cnt <= DLY;
            stg <= conv_stage;
         end else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_data <= {12'hA50, stg};
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule // cpcb_conv_model

// >>> sim/test_cdc_power_config_bank.sv
`timescale 1ns/10ps

module test_cdc_power_config_bank;
   localparam int FP = 200;
   localparam int LP = 100;
   logic        core_clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
   logic        link_addr_load = 1'b0, link_byte_valid = 1'b0, link_rd_req = 1'b0;
   logic [9:0]  link_addr = 10'h000;
   logic [7:0]  link_byte = 8'h00;
   logic        link_busy, link_rd_valid, conv_done, conv_start;
   logic        excitation_enable, int_active_high;
   logic [15:0] link_rd_data, conv_data;
   logic [3:0]  conv_stage;
   logic [8:0]  decim_ratio;
   logic [1:0]  bias_trim;
   int          fails = 0, n_checks = 0, cyc = 0, last0 = 0, gap = 0, maxstg = 0, nstart = 0;
   logic [15:0] boot [8] = '{16'h82B2, 16'h0000, 16'h3230, 16'h0419, 16'h0832, 16'h0000,
                             16'h0000, 16'h0000};

   cpcb_top #(.FP_PERIOD_CYC(FP), .LP_STEP_CYC(LP)) i_dut (.core_clk, .reset_n, .link_clk,
      .link_addr_load, .link_addr, .link_byte_valid, .link_byte, .link_rd_req, .link_busy,
      .link_rd_valid, .link_rd_data, .conv_done, .conv_data, .conv_start, .conv_stage,
      .decim_ratio, .excitation_enable, .bias_trim, .int_active_high);
   cpcb_conv_model #(.DLY(4)) i_conv (.core_clk, .reset_n, .conv_start, .conv_stage,
      .conv_done, .conv_data);

   always #10 core_clk = ~core_clk;
   initial begin
      #2.7;
      forever #6 link_clk = ~link_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (conv_start === 1'b1) begin
         nstart++;
         if (conv_stage === 4'h0) begin
            gap = cyc - last0;
            last0 = cyc;
         end
         if (int'(conv_stage) > maxstg) maxstg = conv_stage;
      end
   end

   task automatic wrap_up();
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic set_addr(input logic [9:0] a);
      @(negedge link_clk);
      link_addr_load = 1'b1;
      link_addr = a;
      @(negedge link_clk);
      link_addr_load = 1'b0;
   endtask

   // Enters and leaves on a falling link edge with busy low
   task automatic put_word(input logic [15:0] d);
      int n;
      link_byte_valid = 1'b1;
      link_byte = d[15:8];
      @(negedge link_clk);
      link_byte = d[7:0];
      @(negedge link_clk);
      link_byte_valid = 1'b0;
      for (n = 0; n < 50 && link_busy !== 1'b0; n++) @(negedge link_clk);
      if (n == 50) chk(1, 0);
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      int n;
      logic [15:0] d;
      d = 16'hXXXX;
      set_addr(a);
      link_rd_req = 1'b1;
      @(negedge link_clk);
      link_rd_req = 1'b0;
      for (n = 0; n < 50; n++) begin
         @(posedge link_clk);
         #1;
         if (link_rd_valid === 1'b1) break;
      end
      if (n == 50) chk(1, 0);
      d = link_rd_data;
      @(negedge link_clk);
      chk(d, exp);
   endtask

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      set_addr(a);
      put_word(d);
      repeat (3) @(negedge core_clk);
   endtask

   task automatic t_startup();
      set_addr(10'h080);
      for (int i = 0; i < 96; i++) put_word(16'h1000 + 16'(i));
      rd(10'h088, 16'h1008);
      rd(10'h0DF, 16'h105F);
      set_addr(10'h000);
      foreach (boot[i]) put_word(boot[i]);
      rd(10'h000, 16'h82B2);
      rd(10'h003, 16'h0419);
      chk(decim_ratio, 9'h040);
      chk(bias_trim, 2'h2);
      wr(10'h001, 16'h0FFF);
      rd(10'h001, 16'h0FFF);
      rd(10'h008, 16'h0000);
   endtask

   task automatic t_fields();
      logic [15:0] w;
      for (int i = 0; i < 4; i++) begin
         w = {i[1:0], 1'b1, i[0], i[1], 1'b0, i[1:0], 8'h01};
         wr(10'h000, w);
         // A sequence may still start before shutdown lands
         if (i == 0) nstart = 0;
         chk(decim_ratio, i == 0 ? 9'h100 : i == 1 ? 9'h080 : 9'h040);
         chk(excitation_enable, !i[0]);
         chk(bias_trim, i[1:0]);
         chk(int_active_high, i[1]);
         rd(10'h000, w & 16'hDFFF);
      end
      chk(nstart, 0);
   endtask

   task automatic t_rate(input logic [15:0] w, input int exp_gap, input int exp_max);
      wr(10'h000, w);
      maxstg = 0;
      repeat (3 * exp_gap) @(negedge core_clk);
      chk(gap, exp_gap);
      chk(maxstg, exp_max);
   endtask

   task automatic t_soft();
      wr(10'h000, 16'h04B6);
      rd(10'h000, 16'h0000);
      rd(10'h001, 16'h0000);
      chk(decim_ratio, 9'h100);
      chk(excitation_enable, 1'b1);
      wr(10'h050, 16'hFFFF);
      rd(10'h050, 16'h0000);
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      reset_n = 1'b1;
      repeat (3) @(negedge link_clk);
      rd(10'h000, 16'h0000);
      chk(decim_ratio, 9'h100);
      chk(excitation_enable, 1'b1);
      t_startup();
      t_fields();
      t_rate(16'h0020, FP, 2);
      t_rate(16'h00B6, 2 * LP, 11);
      t_rate(16'h00CE, 4 * LP, 11);
      rd(10'h0E0, 16'hA500);
      rd(10'h104, 16'hA501);
      rd(10'h26C, 16'hA50B);
      t_soft();
      wrap_up();
   end

   // Whole sequence needs well under ten thousand core cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
endmodule // test_cdc_power_config_bank
